// *** scq_engine.sv ***
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - interrupt queue is a fifo in external ram, one entry per threshold hit while fewer than 256 entries wait in ram
// - queue-not-empty status flag is 1 while any entry is held
// - interrupt pin asserts when queue-not-empty is set and not masked
// - enabled: queue window ignores address bits 12:0, each read with the head prefetched pops it
// - each entry carries port, channel and counter index
// - clear-on-read set and enabled: host read of a counter zeroes it afterwards
// - each returned entry carries the queue-not-empty indication
// - disabled: host may read and write all ram including queue
// - enabled: engine fetches events while the event queue is not empty
// - engine reads counter value and threshold record per event
// - add increment only below 4000_0000 hex, else leave unchanged
// - active threshold and counter at or above level writes queue entry unless the ram queue already holds 256
// - last step writes new counter value with interrupt-generated flag
// - enabled: queue reachable only through window, direct access blocked
// - inactive threshold never produces an entry
// - event queue is a fifo of 256 events
// - each event carries counter ram address and increment
module scq_engine
  import scq_pkg::*;
(
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                reset,
  // counter events
  input  wire logic                ev_valid,
  input  wire logic [RAM_AW-1:0]   ev_addr,
  input  wire logic [EV_IW-1:0]    ev_incr,
  output logic                     ev_ready,
  // host register port
  input  wire logic [HOST_AW-1:0]  host_address_bus,
  input  wire logic [HOST_DW-1:0]  host_wdata,
  input  wire logic                host_wr,
  input  wire logic                host_rd,
  output logic      [HOST_DW-1:0]  host_rdata,
  output logic                     host_interrupt_pin,
  // external statistics ram
  output logic      [RAM_AW-1:0]   ram_addr,
  output logic      [RAM_DW-1:0]   ram_wdata,
  output logic                     ram_we,
  output logic                     ram_re,
  input  wire logic [RAM_DW-1:0]   ram_rdata
);
  import scq_pkg::*;

  typedef struct packed {
    scq_state_t        st;
    logic [8:0]        eq_cnt;
    logic [EQ_AW-1:0]  eq_wp;
    logic [EQ_AW-1:0]  eq_rp;
    logic [15:0]       ev_addr;
    logic [EV_IW-1:0]  ev_incr;
    logic [31:0]       cnt_word;
    logic [30:0]       new_cnt;
    logic              int_flag;
    logic [8:0]        iq_cnt;
    logic [IQ_AW-1:0]  iq_wp;
    logic [IQ_AW-1:0]  iq_rp;
    logic              hb_vld;
    logic [ENT_W-1:0]  hb_ent;
    logic              en;
    logic              cor;
    logic              mask;
    logic [15:0]       mb_addr;
    logic [31:0]       mb_data;
    logic [31:0]       mb_wdata;
    logic              mb_rd_pend;
    logic              mb_wr_pend;
    logic              mb_clr_pend;
    logic [31:0]       rdata;
    logic              irq;
    logic              ev_ready;
    logic [15:0]       ram_addr;
    logic [31:0]       ram_wdata;
    logic              ram_we;
    logic              ram_re;
  } scq_regs_t;

  scq_regs_t        st_r;
  scq_regs_t        st_nxt;
  logic             eq_push;
  logic             eq_pop;
  logic [31:0]      eq_rdata;
  logic [30:0]      sa_cnt;
  logic             sa_hit;
  logic             ne_w;
  logic             busy_w;
  logic [4:0]       h_page;
  logic [12:0]      h_ofs;

  assign ne_w   = st_r.hb_vld || (st_r.iq_cnt != 9'h000);
  // a fetch still in flight counts as busy, else a poll could read stale mailbox data
  assign busy_w = st_r.mb_rd_pend || st_r.mb_wr_pend || st_r.mb_clr_pend
                  || st_r.st == ST_MB_W || st_r.st == ST_MB_CAP;
  assign h_page = host_address_bus[17:13];
  assign h_ofs  = host_address_bus[12:0];
  assign eq_push = ev_valid && st_r.ev_ready;

  // event queue storage, one word per event
  scq_mem #(
    .W (32),
    .A (EQ_AW)
  ) u_evq (
    .sys_clk (sys_clk),
    .reset   (reset),
    .wr_en   (eq_push),
    .wr_addr (st_r.eq_wp),
    .wr_data ({ev_addr, ev_incr}),
    .rd_en   (eq_pop),
    .rd_addr (st_r.eq_rp),
    .rd_data (eq_rdata)
  );

  scq_satadd u_sat (
    .cnt      (st_r.cnt_word[30:0]),
    .incr     (st_r.ev_incr),
    .thr_word (ram_rdata),
    .new_cnt  (sa_cnt),
    .hit      (sa_hit)
  );

  always_comb begin
    st_nxt = st_r;
    eq_pop = 1'b0;
    st_nxt.ram_we = 1'b0;
    st_nxt.ram_re = 1'b0;
    st_nxt.rdata  = '0;
    if (eq_push) begin
      st_nxt.eq_wp = st_r.eq_wp + 8'h01;
    end
    case (st_r.st)
      ST_IDLE: begin
        // host ram work only between events, never inside a read-modify-write
        if (st_r.mb_clr_pend) begin
          st_nxt.ram_we      = 1'b1;
          st_nxt.ram_addr    = st_r.mb_addr;
          st_nxt.ram_wdata   = '0;
          st_nxt.mb_clr_pend = 1'b0;
        end else if (st_r.mb_wr_pend) begin
          st_nxt.ram_we     = 1'b1;
          st_nxt.ram_addr   = st_r.mb_addr;
          st_nxt.ram_wdata  = st_r.mb_wdata;
          st_nxt.mb_wr_pend = 1'b0;
        end else if (st_r.mb_rd_pend) begin
          st_nxt.ram_re     = 1'b1;
          st_nxt.ram_addr   = st_r.mb_addr;
          st_nxt.mb_rd_pend = 1'b0;
          st_nxt.st         = ST_MB_W;
        end else if (st_r.en && !st_r.hb_vld && st_r.iq_cnt != 9'h000) begin
          st_nxt.ram_re   = 1'b1; // prefetch head so window reads answer at once
          st_nxt.ram_addr = {IQ_PAGE, st_r.iq_rp};
          st_nxt.st       = ST_IQ_W;
        end else if (st_r.en && st_r.eq_cnt != 9'h000) begin
          eq_pop       = 1'b1;
          st_nxt.eq_rp = st_r.eq_rp + 8'h01;
          st_nxt.st    = ST_EV_LD;
        end
      end
      ST_EV_LD: begin
        st_nxt.ev_addr  = eq_rdata[31:16];
        st_nxt.ev_incr  = eq_rdata[15:0];
        st_nxt.ram_re   = 1'b1;
        st_nxt.ram_addr = eq_rdata[31:16];
        st_nxt.st       = ST_CNT_W;
      end
      ST_CNT_W: st_nxt.st = ST_CNT_CAP;
      ST_CNT_CAP: begin
        st_nxt.cnt_word = ram_rdata;
        st_nxt.ram_re   = 1'b1;
        st_nxt.ram_addr = {st_r.ev_addr[15:1], 1'b1};
        st_nxt.st       = ST_THR_W;
      end
      ST_THR_W: st_nxt.st = ST_THR_CAP;
      ST_THR_CAP: begin
        st_nxt.new_cnt = sa_cnt;
        // a full queue drops the entry and the record says none was made
        st_nxt.int_flag = sa_hit && (st_r.iq_cnt != IQ_FULL);
        if (sa_hit && st_r.iq_cnt != IQ_FULL) begin
          st_nxt.ram_we    = 1'b1;
          st_nxt.ram_addr  = {IQ_PAGE, st_r.iq_wp};
          st_nxt.ram_wdata = {18'h0_0000, cnt_id(st_r.ev_addr)};
          st_nxt.iq_wp     = st_r.iq_wp + 8'h01;
          st_nxt.iq_cnt    = st_r.iq_cnt + 9'h001;
        end
        st_nxt.st = ST_WR_CNT;
      end
      ST_WR_CNT: begin
        st_nxt.ram_we    = 1'b1;
        st_nxt.ram_addr  = st_r.ev_addr;
        st_nxt.ram_wdata = {st_r.int_flag, st_r.new_cnt};
        st_nxt.st        = ST_IDLE;
      end
      ST_IQ_W: st_nxt.st = ST_IQ_CAP;
      ST_IQ_CAP: begin
        st_nxt.hb_ent = ram_rdata[ENT_W-1:0];
        st_nxt.hb_vld = 1'b1;
        st_nxt.iq_rp  = st_r.iq_rp + 8'h01;
        st_nxt.iq_cnt = st_r.iq_cnt - 9'h001;
        st_nxt.st     = ST_IDLE;
      end
      ST_MB_W: st_nxt.st = ST_MB_CAP;
      ST_MB_CAP: begin
        st_nxt.mb_data = ram_rdata;
        st_nxt.st      = ST_IDLE;
      end
      default: st_nxt.st = ST_IDLE;
    endcase
    // host side comes last so a new request beats the engine clearing it
    if (host_wr && h_page == HREG_PAGE) begin
      case (h_ofs)
        OFS_CTRL: begin
          st_nxt.en  = host_wdata[CTRL_EN_BIT];
          st_nxt.cor = host_wdata[CTRL_COR_BIT];
        end
        OFS_MASK:  st_nxt.mask = host_wdata[0];
        OFS_MBADR: begin
          st_nxt.mb_addr    = host_wdata[15:0];
          st_nxt.mb_rd_pend = !(st_r.en && is_iq_addr(host_wdata[15:0]));
        end
        OFS_MBDAT: begin
          st_nxt.mb_wdata   = host_wdata;
          st_nxt.mb_wr_pend = !(st_r.en && is_iq_addr(st_r.mb_addr));
        end
        default: ;
      endcase
    end
    if (host_rd && h_page == HREG_PAGE) begin
      case (h_ofs)
        OFS_CTRL:  st_nxt.rdata = {30'h0000_0000, st_r.cor, st_r.en};
        OFS_STAT:  st_nxt.rdata = {21'h00_0000, st_r.iq_cnt, busy_w, ne_w};
        OFS_MASK:  st_nxt.rdata = {31'h0000_0000, st_r.mask};
        OFS_MBADR: st_nxt.rdata = {16'h0000, st_r.mb_addr};
        OFS_MBDAT: begin
          st_nxt.rdata = st_r.mb_data;
          if (st_r.cor && st_r.en && is_cnt_addr(st_r.mb_addr) && !busy_w) begin
            st_nxt.mb_clr_pend = 1'b1;
          end
        end
        default: st_nxt.rdata = '0;
      endcase
    end else if (host_rd && h_page == HIQ_PAGE && st_r.en) begin
      // bits 12:0 are not decoded here
      if (st_r.hb_vld) begin
        st_nxt.rdata = {(st_r.iq_cnt != 9'h000), 1'b1, 16'h0000, st_r.hb_ent};
        st_nxt.hb_vld = 1'b0;
      end else begin
        st_nxt.rdata = {ne_w, 31'h0000_0000};
      end
    end
    if (eq_push && !eq_pop) begin
      st_nxt.eq_cnt = st_r.eq_cnt + 9'h001;
    end else if (!eq_push && eq_pop) begin
      st_nxt.eq_cnt = st_r.eq_cnt - 9'h001;
    end
    st_nxt.ev_ready = st_nxt.eq_cnt < EQ_FULL;
    st_nxt.irq = (st_nxt.hb_vld || st_nxt.iq_cnt != 9'h000) && !st_nxt.mask;
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      st_r          <= '0;
      st_r.st       <= ST_IDLE;
      st_r.ev_ready <= 1'b1;
      st_r.mask     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign ev_ready           = st_r.ev_ready;
  assign host_rdata         = st_r.rdata;
  assign host_interrupt_pin = st_r.irq;
  assign ram_addr           = st_r.ram_addr;
  assign ram_wdata          = st_r.ram_wdata;
  assign ram_we             = st_r.ram_we;
  assign ram_re             = st_r.ram_re;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  a_stat_ne: assert property (
    host_rd && h_page == HREG_PAGE && h_ofs == OFS_STAT && ne_w |=> host_rdata[STAT_NE_BIT])
    else $error("status read lost queue-not-empty");
  a_irq_gate: assert property (
    host_interrupt_pin |-> !$past(st_nxt.mask) && $past(st_nxt.iq_cnt != 9'h000 || st_nxt.hb_vld))
    else $error("interrupt pin without unmasked pending entry");
  a_iq_advance: assert property (
    host_rd && h_page == HIQ_PAGE && st_r.en && st_r.hb_vld
      |=> host_rdata[IQ_VLD_BIT] && !st_r.hb_vld)
    else $error("window read did not return and pop the head");
  a_entry_id: assert property (
    st_r.st == ST_THR_CAP && sa_hit && st_r.iq_cnt != IQ_FULL
      |=> ram_we && is_iq_addr(ram_addr) && ram_wdata[13:0] == cnt_id($past(st_r.ev_addr)))
    else $error("queue entry not written with counter identity");
  a_clear_read: assert property (
    st_r.st == ST_IDLE && st_r.mb_clr_pend |=> ram_we && ram_wdata == 32'h0000_0000)
    else $error("clear-on-read did not zero the counter");
  a_final_write: assert property (
    st_r.st == ST_WR_CNT |=> ram_we && ram_addr == $past(st_r.ev_addr)
      && ram_wdata[INT_GEN_BIT] == $past(st_r.int_flag))
    else $error("final counter write missing or wrong");
  a_sat_limit: assert property (
    st_r.st == ST_THR_CAP && st_r.cnt_word[30:0] >= CNT_MAX
      |=> st_r.new_cnt == $past(st_r.cnt_word[30:0]))
    else $error("saturated counter changed");
  a_no_inactive: assert property (
    st_r.st == ST_THR_CAP && !ram_rdata[THR_ACT_BIT]
      |=> !st_r.int_flag && !(ram_we && is_iq_addr(ram_addr)))
    else $error("inactive threshold produced an entry");
  a_iq_blocked: assert property (
    host_wr && h_page == HREG_PAGE && h_ofs == OFS_MBDAT && st_r.en
      && is_iq_addr(st_r.mb_addr) |=> !st_r.mb_wr_pend)
    else $error("direct queue write accepted while enabled");
  a_ev_fetch: assert property (
    st_r.st == ST_IDLE && st_r.en && st_r.eq_cnt != 9'h000 && !st_r.hb_vld
      |-> ##[1:40] st_r.st == ST_EV_LD)
    else $error("pending event not fetched");
  a_rmw_whole: assert property (
    st_r.st == ST_EV_LD |=> st_r.st == ST_CNT_W ##1 st_r.st == ST_CNT_CAP
      ##1 st_r.st == ST_THR_W ##1 st_r.st == ST_THR_CAP ##1 st_r.st == ST_WR_CNT)
    else $error("event update interrupted");

endmodule // scq_engine
`default_nettype wire

// *** scq_mem.sv ***
`timescale 1ns/100ps
`default_nettype none
module scq_mem #(
  parameter int W = 32,
  parameter int A = 8
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         reset,
  // write side
  input  wire logic         wr_en,
  input  wire logic [A-1:0] wr_addr,
  input  wire logic [W-1:0] wr_data,
  // read side, data registered
  input  wire logic         rd_en,
  input  wire logic [A-1:0] rd_addr,
  output logic      [W-1:0] rd_data
);

  logic [W-1:0] mem_r [0:(1<<A)-1];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem_r[rd_addr];
    end
  end

endmodule // scq_mem
`default_nettype wire

// *** scq_pkg.sv ***
`default_nettype none
package scq_pkg;

  // widths
  localparam int RAM_AW  = 16;
  localparam int RAM_DW  = 32;
  localparam int HOST_AW = 18;
  localparam int HOST_DW = 32;
  localparam int EV_IW   = 16;
  localparam int EQ_AW   = 8;
  localparam int IQ_AW   = 8;
  localparam int ENT_W   = 14;

  // queue limits
  localparam logic [8:0]  EQ_FULL = 9'h100;
  localparam logic [8:0]  IQ_FULL = 9'h100;

  // counter record layout
  localparam logic [30:0] CNT_MAX     = 31'h4000_0000;
  localparam int          INT_GEN_BIT = 31;
  localparam int          THR_ACT_BIT = 31;

  // interrupt queue location in external ram
  localparam logic [7:0]  IQ_PAGE = 8'h01;

  // host address map
  localparam logic [4:0]  HREG_PAGE = 5'h00;
  localparam logic [4:0]  HIQ_PAGE  = 5'h01;
  localparam logic [12:0] OFS_CTRL  = 13'h0000;
  localparam logic [12:0] OFS_STAT  = 13'h0004;
  localparam logic [12:0] OFS_MASK  = 13'h0008;
  localparam logic [12:0] OFS_MBADR = 13'h000C;
  localparam logic [12:0] OFS_MBDAT = 13'h0010;

  // register bits
  localparam int CTRL_EN_BIT  = 0;
  localparam int CTRL_COR_BIT = 1;
  localparam int STAT_NE_BIT  = 0;
  localparam int STAT_BSY_BIT = 1;
  localparam int QUEUE_NOT_EMPTY_FLAG_BIT    = 31;
  localparam int IQ_VLD_BIT   = 30;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_EV_LD   = 4'h1,
    ST_CNT_W   = 4'h2,
    ST_CNT_CAP = 4'h3,
    ST_THR_W   = 4'h4,
    ST_THR_CAP = 4'h5,
    ST_WR_CNT  = 4'h6,
    ST_IQ_W    = 4'h7,
    ST_IQ_CAP  = 4'h8,
    ST_MB_W    = 4'h9,
    ST_MB_CAP  = 4'hA
  } scq_state_t;

  // counters live in the upper half of ram, threshold record at odd word
  function automatic logic is_cnt_addr(input logic [15:0] a);
    return a[15];
  endfunction

  function automatic logic is_iq_addr(input logic [15:0] a);
    return a[15:8] == IQ_PAGE;
  endfunction

  // {port_index[2:0], channel_index[4:0], counter_index[5:0]}
  function automatic logic [13:0] cnt_id(input logic [15:0] a);
    return a[14:1];
  endfunction

endpackage
`default_nettype wire

// *** scq_ram_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module scq_ram_model (
  // clock
  input  wire logic        sys_clk,
  // engine side
  input  wire logic [15:0] ram_addr,
  input  wire logic [31:0] ram_wdata,
  input  wire logic        ram_we,
  input  wire logic        ram_re,
  output wire logic [31:0] ram_rdata
);
  logic [31:0] mem [0:65535];
  logic [31:0] q_r;
  logic        vld_r;
  // data stand one cycle only; the inverse afterwards exposes a late sample
  assign ram_rdata = vld_r ? q_r : ~q_r;
  always_ff @(posedge sys_clk) begin
    vld_r <= ram_re;
    if (ram_re) begin
      q_r <= mem[ram_addr];
    end
    if (ram_we) begin
      mem[ram_addr] <= ram_wdata;
    end
  end
endmodule // scq_ram_model
`default_nettype wire

// *** scq_satadd.sv ***
`timescale 1ns/100ps
`default_nettype none
module scq_satadd
  import scq_pkg::*;
(
  // operands
  input  wire logic [30:0]      cnt,
  input  wire logic [EV_IW-1:0] incr,
  input  wire logic [31:0]      thr_word,
  // results
  output logic      [30:0]      new_cnt,
  output logic                  hit
);

  logic [31:0] sum;

  always_comb begin
    sum = {1'b0, cnt} + {16'h0000, incr};
    if (cnt >= CNT_MAX) begin
      new_cnt = cnt;
    end else if (sum[30:0] > CNT_MAX || sum[31]) begin
      new_cnt = CNT_MAX; // clamp so the record never passes the top
    end else begin
      new_cnt = sum[30:0];
    end
    hit = thr_word[THR_ACT_BIT] && (new_cnt >= thr_word[30:0]);
  end

endmodule // scq_satadd
`default_nettype wire

// *** test_scq_engine.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_scq_engine;
  import scq_pkg::*;
  localparam logic [17:0] A_CTRL  = {HREG_PAGE, OFS_CTRL};
  localparam logic [17:0] A_STAT  = {HREG_PAGE, OFS_STAT};
  localparam logic [17:0] A_MASK  = {HREG_PAGE, OFS_MASK};
  localparam logic [17:0] A_MBADR = {HREG_PAGE, OFS_MBADR};
  localparam logic [17:0] A_MBDAT = {HREG_PAGE, OFS_MBDAT};
  localparam logic [17:0] A_NONE  = {HREG_PAGE, 13'h0014};
  localparam logic [17:0] A_IQ0   = {HIQ_PAGE, 13'h0000};
  localparam logic [17:0] A_IQ1   = {HIQ_PAGE, 13'h1FFE};
  // counter word, threshold word pairs: hit at equal level, clamp, below level, at max
  localparam logic [15:0] IA [8] = '{16'hD4C2, 16'hD4C3, 16'h8004, 16'h8005,
                                     16'h8008, 16'h8009, 16'h8006, 16'h8007};
  localparam logic [31:0] IV [8] = '{32'h0000_0005, 32'h8000_000C, 32'h3FFF_FFFF, 32'h0000_0001,
                                     32'h0000_0000, 32'h8000_0005, 32'h4000_0000, 32'hB000_0000};
  localparam logic [15:0] INC [4] = '{16'h0007, 16'h0005, 16'h0004, 16'h0003};
  localparam logic [31:0] EC [4] = '{32'h8000_000C, 32'h4000_0000, 32'h0000_0004, 32'hC000_0000};
  logic                sys_clk;
  logic                reset;
  logic                ev_valid;
  logic [RAM_AW-1:0]   ev_addr;
  logic [EV_IW-1:0]    ev_incr;
  logic                ev_ready;
  logic [HOST_AW-1:0]  host_address_bus;
  logic [HOST_DW-1:0]  host_wdata;
  logic                host_wr;
  logic                host_rd;
  logic [HOST_DW-1:0]  host_rdata;
  logic                host_interrupt_pin;
  logic [RAM_AW-1:0]   ram_addr;
  logic [RAM_DW-1:0]   ram_wdata;
  logic                ram_we;
  logic                ram_re;
  wire logic [RAM_DW-1:0] ram_rdata;
  int                  n_fail;
  int                  cmp_count;
  logic [31:0]         d;

  scq_engine DUT (.sys_clk(sys_clk), .reset(reset), .ev_valid(ev_valid), .ev_addr(ev_addr),
    .ev_incr(ev_incr), .ev_ready(ev_ready), .host_address_bus(host_address_bus),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
    .host_interrupt_pin(host_interrupt_pin), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));
  scq_ram_model ram (.sys_clk(sys_clk), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .ram_we(ram_we), .ram_re(ram_re), .ram_rdata(ram_rdata));

  always #20 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic hwr(input logic [17:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    host_wr <= 1'b1;
    host_address_bus <= a;
    host_wdata <= v;
    @(posedge sys_clk);
    host_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic hrd(input logic [17:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    host_rd <= 1'b1;
    host_address_bus <= a;
    @(posedge sys_clk);
    host_rd <= 1'b0;
    #1;
    v = host_rdata;
  endtask

  task automatic mb_wait;
    logic [31:0] s;
    int k;
    k = 0;
    s = 32'h0000_0002;
    while (s[STAT_BSY_BIT] !== 1'b0 && k < 100) begin
      hrd(A_STAT, s);
      k++;
    end
    chk("mailbox idle", 32'h0000_0000, {31'h0, s[STAT_BSY_BIT]});
  endtask

  task automatic ram_wr(input logic [15:0] a, input logic [31:0] v);
    hwr(A_MBADR, {16'h0000, a});
    mb_wait();
    hwr(A_MBDAT, v);
    mb_wait();
  endtask

  task automatic ram_rd(input logic [15:0] a, output logic [31:0] v);
    hwr(A_MBADR, {16'h0000, a});
    mb_wait();
    hrd(A_MBDAT, v);
  endtask

  task automatic push(input logic [15:0] a, input logic [15:0] inc);
    int k;
    k = 0;
    @(posedge sys_clk);
    ev_valid <= 1'b1;
    ev_addr <= a;
    ev_incr <= inc;
    @(posedge sys_clk);
    while (ev_ready !== 1'b1 && k < 50) begin
      @(posedge sys_clk);
      k++;
    end
    ev_valid <= 1'b0;
  endtask

  // invalid window reads do not pop, so retry until an entry shows
  task automatic iq_pop(input logic [17:0] a, input logic [31:0] exp);
    logic [31:0] v;
    int k;
    k = 0;
    v = 32'h0000_0000;
    while (v[IQ_VLD_BIT] !== 1'b1 && k < 20) begin
      hrd(a, v);
      k++;
    end
    chk("queue entry", exp, v);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (12000) @(posedge sys_clk);
    n_fail++;
    $display("mismatch watchdog expected done seen timeout");
    report_and_stop();
  end

  initial begin
    sys_clk = 1'b0;
    reset = 1'b1;
    ev_valid = 1'b0;
    ev_addr = '0;
    ev_incr = '0;
    host_address_bus = '0;
    host_wdata = '0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    n_fail = 0;
    cmp_count = 0;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    hrd(A_CTRL, d);
    chk("control", 32'h0000_0000, d);
    hrd(A_STAT, d);
    chk("status", 32'h0000_0000, d);
    hrd(A_MASK, d);
    chk("mask", 32'h0000_0001, d);
    hrd(A_NONE, d);
    chk("unmapped", 32'h0000_0000, d);
    hrd(A_IQ0, d);
    chk("window off", 32'h0000_0000, d);
    chk("pin", 32'h0000_0000, {31'h0, host_interrupt_pin});
    chk("ready", 32'h0000_0001, {31'h0, ev_ready});
    $display("test reset done");
    // engine off: every ram word, queue area included, is open
    for (int i = 0; i < 8; i++) ram_wr(IA[i], IV[i]);
    ram_wr(16'h0105, 32'h1234_5678);
    ram_wr(16'h8010, 32'h0000_0000);
    ram_wr(16'h8011, 32'h0000_0000);
    ram_rd(16'h0105, d);
    chk("queue word", 32'h1234_5678, d);
    for (int i = 0; i < 4; i++) push(IA[2*i], INC[i]);
    hwr(A_CTRL, 32'h0000_0001);
    repeat (150) @(posedge sys_clk);
    hrd(A_STAT, d);
    chk("not empty", 32'h0000_0001, {31'h0, d[STAT_NE_BIT]});
    chk("pin masked", 32'h0000_0000, {31'h0, host_interrupt_pin});
    hwr(A_MASK, 32'h0000_0000);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("pin open", 32'h0000_0001, {31'h0, host_interrupt_pin});
    for (int i = 0; i < 4; i++) begin
      ram_rd(IA[2*i], d);
      chk("counter", EC[i], d);
    end
    iq_pop(A_IQ0, 32'hC000_2A61);
    iq_pop(A_IQ1, 32'h4000_0003);
    repeat (6) @(posedge sys_clk);
    hrd(A_IQ1, d);
    chk("window empty", 32'h0000_0000, d);
    hrd(A_STAT, d);
    chk("empty", 32'h0000_0000, {31'h0, d[STAT_NE_BIT]});
    chk("pin idle", 32'h0000_0000, {31'h0, host_interrupt_pin});
    $display("test events done");
    // engine on: direct queue access is blocked, mailbox keeps the old word
    hwr(A_MBADR, 32'h0000_0105);
    mb_wait();
    hrd(A_MBDAT, d);
    chk("stale word", 32'hC000_0000, d);
    hrd(A_MBADR, d);
    chk("mailbox address", 32'h0000_0105, d);
    hwr(A_MBDAT, 32'hDEAD_BEEF);
    mb_wait();
    hwr(A_CTRL, 32'h0000_0000);
    ram_rd(16'h0105, d);
    chk("queue kept", 32'h1234_5678, d);
    hwr(A_CTRL, 32'h0000_0003);
    hrd(A_CTRL, d);
    chk("control set", 32'h0000_0003, d);
    ram_rd(IA[0], d);
    chk("read clear", 32'h8000_000C, d);
    mb_wait();
    ram_rd(IA[0], d);
    chk("cleared", 32'h0000_0000, d);
    $display("test host access done");
    hwr(A_CTRL, 32'h0000_0000);
    for (int i = 0; i < 256; i++) push(16'h8010, 16'h0001);
    @(posedge sys_clk);
    #1;
    chk("queue full", 32'h0000_0000, {31'h0, ev_ready});
    @(posedge sys_clk);
    ev_valid <= 1'b1;
    ev_incr <= 16'h0100;
    repeat (3) @(posedge sys_clk);
    ev_valid <= 1'b0;
    hwr(A_CTRL, 32'h0000_0001);
    repeat (3000) @(posedge sys_clk);
    #1;
    chk("drained", 32'h0000_0001, {31'h0, ev_ready});
    ram_rd(16'h8010, d);
    chk("sum", 32'h0000_0100, d);
    $display("test event queue done");
    report_and_stop();
  end
endmodule // test_scq_engine
`default_nettype wire
